//--- rtl/csx_alu.sv
// Combinational result and flag logic for the instruction group.
// Assumes operands are stable while the op code is presented.
`include "csx_defines.svh"
module csx_alu #(
	parameter int DATA_W = 8
) (
	input wire csx_pkg::csx_op_e i_op,
	input wire logic [DATA_W-1:0] i_acc,
	input wire logic [DATA_W-1:0] i_mem,
	input wire logic [DATA_W-1:0] i_imm,
	input wire logic [2:0] i_bit_sel,
	input wire logic [3:0] i_flags,
	output logic [DATA_W-1:0] o_result,
	output logic [3:0] o_flags,
	output logic o_acc_we,
	output logic o_mem_we,
	output logic o_skip
);
	localparam int HALF = DATA_W / 2;
	logic [DATA_W:0] diff;
	logic [HALF:0] low_diff;
	logic [DATA_W-1:0] xor_val;

	// The nibble split and flag positions are written for a byte-wide datapath only.
	if (DATA_W != 8) begin : g_width_check
		$error("csx_alu supports only an 8-bit datapath");
	end

	always_comb begin
		diff = {1'b0, i_acc} - {1'b0, i_imm};
		low_diff = {1'b0, i_acc[HALF-1:0]} - {1'b0, i_imm[HALF-1:0]};
		xor_val = i_acc ^ ((i_op == csx_pkg::CSX_OP_XOR_IMM) ? i_imm : i_mem);
		o_result = '0;
		o_flags = i_flags;
		o_acc_we = 1'b0;
		o_mem_we = 1'b0;
		o_skip = 1'b0;
		case (i_op)
			csx_pkg::CSX_OP_SUB_IMM: begin
				o_result = diff[DATA_W-1:0]; // see (RULE1)
				o_acc_we = 1'b1;
				o_flags[`CSX_FLAG_C] = ~diff[DATA_W];
				o_flags[`CSX_FLAG_NIBBLE_CARRY] = ~low_diff[HALF];
				o_flags[`CSX_FLAG_Z] = (diff[DATA_W-1:0] == '0);
				o_flags[`CSX_FLAG_SIGNED_RANGE] = (i_acc[DATA_W-1] != i_imm[DATA_W-1])
					&& (diff[DATA_W-1] != i_acc[DATA_W-1]);
			end
			csx_pkg::CSX_OP_SWAP_MEM: begin
				o_result = {i_mem[HALF-1:0], i_mem[DATA_W-1:HALF]}; // see (RULE2)
				o_mem_we = 1'b1;
			end
			csx_pkg::CSX_OP_SWAP_ACC: begin
				o_result = {i_mem[HALF-1:0], i_mem[DATA_W-1:HALF]}; // see (RULE3)
				o_acc_we = 1'b1;
			end
			csx_pkg::CSX_OP_SKIP_ZERO: begin
				o_result = i_mem; // see (RULE4)
				o_mem_we = 1'b1;
				o_skip = (i_mem == '0);
			end
			csx_pkg::CSX_OP_SKIP_ZERO_COPY: begin
				o_result = i_mem; // see (RULE5)
				o_acc_we = 1'b1;
				o_skip = (i_mem == '0);
			end
			csx_pkg::CSX_OP_SKIP_BIT_ZERO: begin
				o_skip = ~i_mem[i_bit_sel]; // see (RULE6)
			end
			csx_pkg::CSX_OP_XOR_ACC: begin
				o_result = xor_val; // see (RULE10)
				o_acc_we = 1'b1;
				o_flags[`CSX_FLAG_Z] = (xor_val == '0);
			end
			csx_pkg::CSX_OP_XOR_MEM: begin
				o_result = xor_val; // see (RULE11)
				o_mem_we = 1'b1;
				o_flags[`CSX_FLAG_Z] = (xor_val == '0);
			end
			csx_pkg::CSX_OP_XOR_IMM: begin
				o_result = xor_val; // see (RULE12)
				o_acc_we = 1'b1;
				o_flags[`CSX_FLAG_Z] = (xor_val == '0); // see (RULE13)
			end
			default: begin
				o_result = '0;
			end
		endcase
	end
endmodule : csx_alu

//--- rtl/csx_defines.svh
// Constants for the skip, swap, xor and table-read execution block.
// Assumes it is included by bare name from rtl/ files.
`ifndef CSX_DEFINES_SVH
`define CSX_DEFINES_SVH
`define CSX_FLAG_C 0
`define CSX_FLAG_NIBBLE_CARRY 1
`define CSX_FLAG_Z 2
`define CSX_FLAG_SIGNED_RANGE 3
`define CSX_ACC_RESET 8'h00
`define CSX_TBH_RESET 8'h00
`define CSX_FLAGS_RESET 4'h0
`endif

//--- rtl/csx_exec.sv
// Execution unit for subtract-immediate, nibble swaps, zero-test skips,
// table reads and the xor forms of the 8-bit core.
// Assumes the decoder presents one op per instruction cycle with i_issue,
// data memory read data is valid with the op, and program memory answers
// a table read with i_prog_valid some cycles after o_prog_req.
//
// Functional notes
// (RULE1) Subtract immediate from accumulator; update signed-range, zero, nibble-carry, carry flags.
// (RULE2) Swap nibbles of memory byte in place; flags unchanged.
// (RULE3) Swapped memory byte goes to accumulator; memory and flags unchanged.
// (RULE4) Memory byte rewritten unchanged; skip next instruction when zero; flags unchanged.
// (RULE5) Memory byte copied into accumulator; skip when zero; flags unchanged.
// (RULE6) Skip next instruction only when selected memory bit is zero.
// (RULE7) A taken skip inserts one dummy cycle, making two instruction cycles.
// (RULE8) Table read uses high and low pointers; low byte to memory, high to register.
// (RULE9) Last-page table read uses low pointer alone in the last page.
// (RULE10) Xor of accumulator and memory into accumulator; only zero flag changes.
// (RULE11) Xor of accumulator and memory into memory; accumulator kept; zero flag only.
// (RULE12) Xor of accumulator and immediate into accumulator.
// (RULE13) Xor immediate sets zero flag on zero result, clears it otherwise.
`include "csx_defines.svh"
module csx_exec #(
	parameter int DATA_W = 8,
	parameter int PROG_AW = 11,
	parameter int PTR_HIGH_W = 3,
	parameter bit HAS_PTR_HIGH = 1'b1
) (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_issue,
	input wire csx_pkg::csx_op_e i_op,
	input wire logic [DATA_W-1:0] i_imm,
	input wire logic [2:0] i_bit_sel,
	input wire logic [DATA_W-1:0] i_mem_rdata,
	input wire logic [DATA_W-1:0] i_table_pointer_low,
	input wire logic [PTR_HIGH_W-1:0] i_table_pointer_high,
	input wire logic [PROG_AW-1:0] i_page_base,
	input wire logic [2*DATA_W-1:0] i_prog_rdata,
	input wire logic i_prog_valid,
	output logic o_busy,
	output logic o_dummy_cycle,
	output logic [DATA_W-1:0] o_acc,
	output logic [3:0] o_flags,
	output logic [DATA_W-1:0] o_table_high_byte,
	output logic o_mem_we,
	output logic [DATA_W-1:0] o_mem_wdata,
	output logic o_prog_req,
	output logic [PROG_AW-1:0] o_prog_addr
);
	localparam int LAST_PAGE_W = PROG_AW - DATA_W;

	csx_pkg::csx_state_e state;
	csx_pkg::csx_state_e next_state;
	logic [DATA_W-1:0] acc;
	logic [DATA_W-1:0] next_acc;
	logic [3:0] flags;
	logic [3:0] next_flags;
	logic [DATA_W-1:0] table_high_byte;
	logic [DATA_W-1:0] next_table_high_byte;
	logic mem_we;
	logic next_mem_we;
	logic [DATA_W-1:0] mem_wdata;
	logic [DATA_W-1:0] next_mem_wdata;
	logic prog_req;
	logic next_prog_req;
	logic [PROG_AW-1:0] prog_addr;
	logic [PROG_AW-1:0] next_prog_addr;

	logic [DATA_W-1:0] alu_result;
	logic [3:0] alu_flags;
	logic alu_acc_we;
	logic alu_mem_we;
	logic alu_skip;
	logic [PROG_AW-1:0] cur_page_addr;
	logic [PROG_AW-1:0] last_page_addr;
	logic op_accept;

	if (DATA_W != 8) begin : g_width_check
		$error("csx_exec supports only an 8-bit datapath");
	end
	if (PROG_AW <= DATA_W) begin : g_addr_check
		$error("program address must be wider than a byte");
	end
	// A pointer pair wider than the program address would silently lose its top bits.
	if (HAS_PTR_HIGH && (PTR_HIGH_W + DATA_W > PROG_AW)) begin : g_ptr_check
		$error("high table pointer wider than program address allows");
	end

	csx_alu #(
		.DATA_W(DATA_W)
	) u_alu (
		.i_op(i_op),
		.i_acc(acc),
		.i_mem(i_mem_rdata),
		.i_imm(i_imm),
		.i_bit_sel(i_bit_sel),
		.i_flags(flags),
		.o_result(alu_result),
		.o_flags(alu_flags),
		.o_acc_we(alu_acc_we),
		.o_mem_we(alu_mem_we),
		.o_skip(alu_skip)
	);

	// Without a high pointer the table read stays in the current page.
	always_comb begin
		if (HAS_PTR_HIGH) begin
			cur_page_addr = '0;
			cur_page_addr[DATA_W+PTR_HIGH_W-1:0] = {i_table_pointer_high, i_table_pointer_low};
		end else begin
			cur_page_addr = {i_page_base[PROG_AW-1:DATA_W], i_table_pointer_low};
		end
		last_page_addr = {{LAST_PAGE_W{1'b1}}, i_table_pointer_low};
	end

	// The unit accepts a new op only when idle; the decoder holds off otherwise.
	assign op_accept = i_issue && (state == csx_pkg::CSX_ST_IDLE);
	assign o_busy = (state != csx_pkg::CSX_ST_IDLE);
	assign o_dummy_cycle = (state == csx_pkg::CSX_ST_DUMMY); // see (RULE7)

	always_comb begin
		next_state = state;
		next_acc = acc;
		next_flags = flags;
		next_table_high_byte = table_high_byte;
		next_mem_we = 1'b0;
		next_mem_wdata = mem_wdata;
		next_prog_req = 1'b0;
		next_prog_addr = prog_addr;
		case (state)
			csx_pkg::CSX_ST_IDLE: begin
				if (op_accept) begin
					case (i_op)
						csx_pkg::CSX_OP_TABLE_READ: begin
							next_prog_addr = cur_page_addr; // see (RULE8)
							next_prog_req = 1'b1;
							next_state = csx_pkg::CSX_ST_TABLE_WAIT;
						end
						csx_pkg::CSX_OP_TABLE_READ_LAST: begin
							next_prog_addr = last_page_addr; // see (RULE9)
							next_prog_req = 1'b1;
							next_state = csx_pkg::CSX_ST_TABLE_WAIT;
						end
						default: begin
							if (alu_acc_we) begin
								next_acc = alu_result;
							end
							if (alu_mem_we) begin
								next_mem_we = 1'b1;
								next_mem_wdata = alu_result;
							end
							next_flags = alu_flags;
							if (alu_skip) begin
								next_state = csx_pkg::CSX_ST_DUMMY; // see (RULE7)
							end
						end
					endcase
				end
			end
			csx_pkg::CSX_ST_TABLE_WAIT: begin
				if (i_prog_valid) begin
					next_mem_we = 1'b1; // see (RULE8)
					next_mem_wdata = i_prog_rdata[DATA_W-1:0];
					next_table_high_byte = i_prog_rdata[2*DATA_W-1:DATA_W];
					next_state = csx_pkg::CSX_ST_IDLE;
				end else begin
					next_prog_req = 1'b1;
				end
			end
			csx_pkg::CSX_ST_DUMMY: begin
				next_state = csx_pkg::CSX_ST_IDLE;
			end
			default: begin
				next_state = csx_pkg::CSX_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			state <= csx_pkg::CSX_ST_IDLE;
			acc <= `CSX_ACC_RESET;
			flags <= `CSX_FLAGS_RESET;
			table_high_byte <= `CSX_TBH_RESET;
			mem_we <= 1'b0;
			mem_wdata <= '0;
			prog_req <= 1'b0;
			prog_addr <= '0;
		end else begin
			state <= next_state;
			acc <= next_acc;
			flags <= next_flags;
			table_high_byte <= next_table_high_byte;
			mem_we <= next_mem_we;
			mem_wdata <= next_mem_wdata;
			prog_req <= next_prog_req;
			prog_addr <= next_prog_addr;
		end
	end

	assign o_acc = acc;
	assign o_flags = flags;
	assign o_table_high_byte = table_high_byte;
	assign o_mem_we = mem_we;
	assign o_mem_wdata = mem_wdata;
	assign o_prog_req = prog_req;
	assign o_prog_addr = prog_addr;
endmodule : csx_exec

//--- rtl/csx_pkg.sv
// Types for the skip, swap, xor and table-read execution block.
// Assumes no other package.
package csx_pkg;
	typedef enum logic [3:0] {
		CSX_OP_NONE,
		CSX_OP_SUB_IMM,
		CSX_OP_SWAP_MEM,
		CSX_OP_SWAP_ACC,
		CSX_OP_SKIP_ZERO,
		CSX_OP_SKIP_ZERO_COPY,
		CSX_OP_SKIP_BIT_ZERO,
		CSX_OP_TABLE_READ,
		CSX_OP_TABLE_READ_LAST,
		CSX_OP_XOR_ACC,
		CSX_OP_XOR_MEM,
		CSX_OP_XOR_IMM
	} csx_op_e;
	typedef enum logic [1:0] {
		CSX_ST_IDLE,
		CSX_ST_TABLE_WAIT,
		CSX_ST_DUMMY
	} csx_state_e;
endpackage : csx_pkg

//--- test/csx_exec_properties.sv
// Port-level assertions for the csx_exec execution unit.
// Assumes it is bound to csx_exec and sees only that module's ports.
module csx_exec_properties #(
	parameter int DATA_W = 8
) (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_issue,
	input wire csx_pkg::csx_op_e i_op,
	input wire logic [DATA_W-1:0] i_imm,
	input wire logic [DATA_W-1:0] i_mem_rdata,
	input wire logic i_prog_valid,
	input wire logic o_busy,
	input wire logic o_dummy_cycle,
	input wire logic [DATA_W-1:0] o_acc,
	input wire logic [3:0] o_flags,
	input wire logic o_mem_we,
	input wire logic [DATA_W-1:0] o_mem_wdata,
	input wire logic o_prog_req
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);
	logic tk;
	logic [DATA_W-1:0] swp;
	assign tk = i_issue && !o_busy;
	assign swp = {i_mem_rdata[3:0], i_mem_rdata[7:4]};
	sub_result_a: assert property (tk && i_op == csx_pkg::CSX_OP_SUB_IMM |=>
		o_acc == $past(o_acc) - $past(i_imm) && o_flags[0] == ($past(o_acc) >= $past(i_imm)))
		else $error("subtract result or carry wrong");
	swap_mem_a: assert property (tk && i_op == csx_pkg::CSX_OP_SWAP_MEM |=>
		o_mem_we && o_mem_wdata == $past(swp) && $stable(o_flags))
		else $error("in-place swap wrong");
	swap_acc_a: assert property (tk && i_op == csx_pkg::CSX_OP_SWAP_ACC |=>
		o_acc == $past(swp) && !o_mem_we && $stable(o_flags))
		else $error("swap to accumulator wrong");
	skip_zero_a: assert property (tk && i_op == csx_pkg::CSX_OP_SKIP_ZERO |=>
		o_mem_we && o_mem_wdata == $past(i_mem_rdata) && o_dummy_cycle == (o_mem_wdata == 0))
		else $error("zero-test skip wrong");
	dummy_once_a: assert property (o_dummy_cycle |=> !o_dummy_cycle && !o_busy)
		else $error("dummy cycle not exactly one");
	xor_mem_a: assert property (tk && i_op == csx_pkg::CSX_OP_XOR_MEM |=>
		o_mem_wdata == ($past(o_acc) ^ $past(i_mem_rdata)) && $stable(o_acc)
		&& o_flags[2] == (o_mem_wdata == 0)) else $error("xor to memory wrong");
	xor_imm_a: assert property (tk && i_op == csx_pkg::CSX_OP_XOR_IMM |=>
		o_acc == ($past(o_acc) ^ $past(i_imm)) && o_flags[2] == (o_acc == 0))
		else $error("xor immediate wrong");
	prog_hold_a: assert property (o_prog_req && !i_prog_valid |=> o_prog_req)
		else $error("program request dropped early");
	cover property (o_dummy_cycle);
	cover property (o_prog_req && i_prog_valid);
	cover property (tk && i_op == csx_pkg::CSX_OP_XOR_MEM);
endmodule : csx_exec_properties

bind csx_exec csx_exec_properties #(.DATA_W(DATA_W)) csx_exec_properties_i (
	.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_issue(i_issue), .i_op(i_op), .i_imm(i_imm),
	.i_mem_rdata(i_mem_rdata), .i_prog_valid(i_prog_valid), .o_busy(o_busy),
	.o_dummy_cycle(o_dummy_cycle), .o_acc(o_acc), .o_flags(o_flags), .o_mem_we(o_mem_we),
	.o_mem_wdata(o_mem_wdata), .o_prog_req(o_prog_req));

//--- test/tb_csx_exec.sv
// Round-robin op stream with random operands for csx_exec with a scoreboard on memory writes.
// Assumes the design and the property checker are compiled first.
module tb_csx_exec;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_ref_clk = 1'b0;
	logic i_srst = 1'b1;
	logic i_issue = 1'b0;
	csx_pkg::csx_op_e i_op = csx_pkg::CSX_OP_NONE;
	logic [7:0] i_imm = 8'h00, i_mem_rdata = 8'h00, i_table_pointer_low = 8'h00;
	logic [2:0] i_bit_sel = 3'h0, i_table_pointer_high = 3'h0;
	logic [10:0] i_page_base = 11'h000;
	logic [15:0] i_prog_rdata = 16'h0000;
	logic i_prog_valid = 1'b0;
	logic o_busy, o_dummy_cycle, o_mem_we, o_prog_req;
	logic [7:0] o_acc, o_table_high_byte, o_mem_wdata, acc = 8'h00, th = 8'h00;
	logic [3:0] o_flags, fl = 4'h0;
	logic [10:0] o_prog_addr;
	logic [15:0] mq[$];
	int err_count = 0;
	int n_tests = 0;
	integer seed = 32'h1da87800;
	csx_exec csx_exec_i (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_issue(i_issue),
		.i_op(i_op), .i_imm(i_imm), .i_bit_sel(i_bit_sel), .i_mem_rdata(i_mem_rdata),
		.i_table_pointer_low(i_table_pointer_low), .i_table_pointer_high(i_table_pointer_high),
		.i_page_base(i_page_base), .i_prog_rdata(i_prog_rdata), .i_prog_valid(i_prog_valid),
		.o_busy(o_busy), .o_dummy_cycle(o_dummy_cycle), .o_acc(o_acc), .o_flags(o_flags),
		.o_table_high_byte(o_table_high_byte), .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata),
		.o_prog_req(o_prog_req), .o_prog_addr(o_prog_addr));
	initial begin
		forever #5 i_ref_clk = ~i_ref_clk;
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic end_sim;
		if (err_count == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim
	// Write data and table-high byte are judged together at each write pulse.
	always @(posedge i_ref_clk) begin
		if (o_mem_we === 1'b1) begin
			check({o_table_high_byte, o_mem_wdata}, mq.pop_front());
		end
	end
	task automatic op(input csx_pkg::csx_op_e e);
		logic [7:0] m, x, r;
		logic [2:0] b;
		logic sk;
		m = ($random(seed) % 3 == 0) ? 8'h00 : 8'($random(seed));
		x = 8'($random(seed));
		b = 3'($random(seed));
		sk = 1'b0;
		r = acc - x;
		@(posedge i_ref_clk);
		i_issue <= 1'b1;
		i_op <= e;
		i_imm <= x;
		i_mem_rdata <= m;
		i_bit_sel <= b;
		i_page_base <= 11'($random(seed));
		@(posedge i_ref_clk);
		i_issue <= 1'b0;
		i_mem_rdata <= ~m;
		i_imm <= ~x;
		case (e)
			csx_pkg::CSX_OP_SUB_IMM: begin
				fl = {(acc[7] != x[7]) && (r[7] != acc[7]), r == 8'h00, acc[3:0] >= x[3:0], acc >= x};
				acc = r;
			end
			csx_pkg::CSX_OP_SWAP_MEM: mq.push_back({th, m[3:0], m[7:4]});
			csx_pkg::CSX_OP_SWAP_ACC: acc = {m[3:0], m[7:4]};
			csx_pkg::CSX_OP_SKIP_ZERO: begin
				mq.push_back({th, m});
				sk = m == 8'h00;
			end
			csx_pkg::CSX_OP_SKIP_ZERO_COPY: begin
				acc = m;
				sk = m == 8'h00;
			end
			csx_pkg::CSX_OP_SKIP_BIT_ZERO: sk = !m[b];
			csx_pkg::CSX_OP_XOR_MEM: begin
				mq.push_back({th, acc ^ m});
				fl[2] = (acc ^ m) == 8'h00;
			end
			default: begin
				acc = acc ^ ((e == csx_pkg::CSX_OP_XOR_ACC) ? m : x);
				fl[2] = acc == 8'h00;
			end
		endcase
		#1;
		check(o_acc, acc);
		check(o_flags, fl);
		check(o_dummy_cycle, sk);
		check(o_busy, sk);
	endtask : op
	task automatic tbl(input bit last);
		logic [15:0] w;
		logic [7:0] pl;
		logic [2:0] ph;
		w = 16'($random(seed));
		pl = 8'($random(seed));
		ph = 3'($random(seed));
		@(posedge i_ref_clk);
		i_issue <= 1'b1;
		i_op <= last ? csx_pkg::CSX_OP_TABLE_READ_LAST : csx_pkg::CSX_OP_TABLE_READ;
		i_table_pointer_low <= pl;
		i_table_pointer_high <= ph;
		@(posedge i_ref_clk);
		i_issue <= 1'b0;
		i_table_pointer_low <= ~pl;
		#1;
		check(o_prog_addr, last ? {3'h7, pl} : {ph, pl});
		check(o_busy, 1'b1);
		// A slow program memory is modelled by a random stall before the word.
		repeat (2'($random(seed))) @(posedge i_ref_clk);
		check(o_prog_req, 1'b1);
		@(posedge i_ref_clk);
		i_prog_valid <= 1'b1;
		i_prog_rdata <= w;
		mq.push_back(w);
		th = w[15:8];
		@(posedge i_ref_clk);
		i_prog_valid <= 1'b0;
		i_prog_rdata <= ~w;
		#1;
		check(o_prog_req, 1'b0);
		check(o_busy, 1'b0);
	endtask : tbl
	initial begin
		repeat (3) @(posedge i_ref_clk);
		i_srst <= 1'b0;
		for (int i = 0; i < 330; i++) begin
			if (i % 11 == 6 || i % 11 == 7) begin
				tbl(i % 11 == 7);
			end else begin
				op(csx_pkg::csx_op_e'(1 + i % 11));
			end
		end
		repeat (3) @(posedge i_ref_clk);
		check(16'(mq.size()), 16'h0000);
		end_sim();
	end
	initial begin
		#100000;
		err_count++;
		end_sim();
	end
endmodule : tb_csx_exec
